// file: verilog/eiv_pkg.sv
/*
 * Shared constants and types for the external interrupt and vector unit.
 * Register offsets, field positions, reset values, sense encodings and
 * vector word addresses live here.
 * Assumes an AXI4-Lite master with 32-bit data, one clock and an active-low
 * asynchronous reset.
 */
// Summary of operation
// RL1: Reset entry at word zero, vectors to eighteen.
// RL2: Pin zero one, change two, pin one thirteen.
// RL3: Second timer words three-five, first overflow six.
// RL4: Serial start word seven, overflow word eight.
// RL5: Memory nine, comparator ten, converter eleven, watchdog twelve.
// RL6: Words fourteen to eighteen for remaining timer sources.
// RL7: Vector fetched only when its source is taken.
// RL8: Pin activity interrupts even when pins drive outputs.
// RL9: Any unmasked pin change toggle raises request.
// RL10: Pin change detection needs no I/O clock; this model detects it through the clocked synchroniser.
// RL11: External pins sense falling, rising or low level.
// RL12: Level mode requests while pin zero stays low.
// RL13: Edge detection uses the I/O clock.
// RL14: Low level on pin zero detected without clock; this model detects it through the clocked synchroniser.
// RL15: Wake source must hold level through start-up.
// RL16: Sense codes: low, change, falling, rising.
// RL17: Pulses longer than one clock are recognised.
// RL18: Edge flag set, cleared by vector or one.
// RL19: Take only with global and individual enable.
// RL20: Lowest pending vector number is served first.
// RL21: Pins synchronised before edge comparison.
package eiv_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_PCMASK = 8'h0C;
  localparam logic [7:0] ADDR_VECTOR = 8'h10;
  localparam logic [7:0] ADDR_PENDING = 8'h14;

  // Field positions within the control register.
  localparam int SENSE_LO_BIT = 0;
  localparam int SENSE_HI_BIT = 1;
  localparam int GLOBAL_EN_BIT = 7;

  // Field positions within the mask and flag registers.
  localparam int MASK_PIN_ONE_BIT = 7;
  localparam int MASK_PIN_ZERO_BIT = 6;
  localparam int MASK_PC_HI_BIT = 5;
  localparam int MASK_PC_LO_BIT = 4;
  localparam int FLAG_PIN_ONE_BIT = 7;
  localparam int FLAG_PIN_ZERO_BIT = 6;
  localparam int FLAG_PC_BIT = 5;

  // Reset value of the sixteen pin change mask bits.
  localparam logic [15:0] PCMASK_RESET = 16'hFFC8;
  // Pin change inputs 11..8 are gated by the low group enable.
  localparam logic [15:0] PC_LO_GROUP = 16'h0F00;

  // Sense control encodings.
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_ANY = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;

  // Number of vectors including reset, and their word addresses.
  localparam int NUM_VEC = 19;
  localparam logic [4:0] VEC_RESET = 5'h00;
  localparam logic [4:0] VEC_PIN_ZERO = 5'h01;
  localparam logic [4:0] VEC_PIN_CHANGE = 5'h02;
  localparam logic [4:0] VEC_TIMER_B_COMPARE_A = 5'h03;
  localparam logic [4:0] VEC_TIMER_B_COMPARE_B = 5'h04;
  localparam logic [4:0] VEC_TIMER_B_OVERFLOW = 5'h05;
  localparam logic [4:0] VEC_TIMER_A_OVERFLOW = 5'h06;
  localparam logic [4:0] VEC_SERIAL_START = 5'h07;
  localparam logic [4:0] VEC_SERIAL_OVERFLOW = 5'h08;
  localparam logic [4:0] VEC_NVM_READY = 5'h09;
  localparam logic [4:0] VEC_COMPARATOR = 5'h0A;
  localparam logic [4:0] VEC_CONVERTER = 5'h0B;
  localparam logic [4:0] VEC_WATCHDOG = 5'h0C;
  localparam logic [4:0] VEC_PIN_ONE = 5'h0D;
  localparam logic [4:0] VEC_TIMER_A_COMPARE_A = 5'h0E;
  localparam logic [4:0] VEC_TIMER_A_COMPARE_B = 5'h0F;
  localparam logic [4:0] VEC_TIMER_CAPTURE = 5'h10;
  localparam logic [4:0] VEC_TIMER_B_COMPARE_D = 5'h11;
  localparam logic [4:0] VEC_FAULT = 5'h12;

  // AXI write and read responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Request from the core: acknowledge of a taken vector.
  typedef struct packed {
    logic ack;
    logic [4:0] vector;
  } eiv_ack_type;

  // Request to the core: pending flag and its vector word.
  typedef struct packed {
    logic req;
    logic [4:0] vector;
  } eiv_req_type;

endpackage : eiv_pkg

// file: verilog/eiv_sync.sv
/*
 * Two flip-flop synchroniser for a bus of asynchronous pin levels.
 * Assumes the inputs come from pins outside the clock domain.
 */
module eiv_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  // First stage, read only by the second stage.
  logic [WIDTH-1:0] meta;

  // Both stages reset to zero, so an idle-high pin shows a rise once real samples arrive.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule : eiv_sync

// file: verilog/eiv_top.sv
/*
 * External interrupt detection and vector selection unit.
 * Senses two dedicated request pins and sixteen pin change inputs, holds
 * the sense, enable and mask settings in AXI4-Lite registers, and presents
 * the lowest pending vector word to the processor core.
 * Assumes the core acknowledges a vector with a one-cycle pulse naming the
 * vector it fetched, and that sources outside this unit arrive as levels
 * already synchronous to i_clk.
 */
module eiv_top (
  input wire logic i_clk,
  input wire logic i_nrst,
  // AXI4-Lite slave.
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Pins, sampled whether they are inputs or driven outputs.
  input wire logic i_ext_irq_pin_zero,
  input wire logic i_ext_irq_pin_one,
  input wire logic [15:0] i_pin_change_inputs,
  // Requests of other on-chip sources, indexed by vector number.
  input wire logic [eiv_pkg::NUM_VEC-1:0] i_periph_req,
  // Core side.
  input wire eiv_pkg::eiv_ack_type i_core_ack,
  output eiv_pkg::eiv_req_type o_core_req,
  output logic o_wake
);

  // Synchronised pin levels and their previous samples.
  logic [17:0] pin_sync;
  logic [17:0] pin_prev;
  // Software settings.
  logic [1:0] sense_control;
  logic global_en;
  logic [7:0] general_irq_mask;
  logic [15:0] pin_change_mask;
  // Sticky flags.
  logic ext_irq_flag_zero;
  logic ext_irq_flag_one;
  logic pin_change_flag;
  // Bus state.
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Pins pass two flip-flops before any comparison. // see RL21
  // Order: pin one, pin zero, change inputs.
  eiv_sync #(
    .WIDTH(18)
  ) u_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_async({i_ext_irq_pin_one, i_ext_irq_pin_zero, i_pin_change_inputs}),
    .o_sync(pin_sync)
  );

  // Remember the previous sample for edge comparison.
  // Stages reset low; level mode at reset
  // ignores the rise of an idle-high pin.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_prev <= '0;
    end else begin
      pin_prev <= pin_sync;
    end
  end

  // Decoded pin events; one clock sample catches longer pulses. // see RL17
  wire [15:0] pc_now = pin_sync[15:0];
  wire [15:0] pc_toggle = pc_now ^ pin_prev[15:0];
  // Inputs 11..8 form the low group.
  wire [15:0] pc_group_en = (eiv_pkg::PC_LO_GROUP &
    {16{general_irq_mask[eiv_pkg::MASK_PC_LO_BIT]}}) |
    (~eiv_pkg::PC_LO_GROUP & {16{general_irq_mask[eiv_pkg::MASK_PC_HI_BIT]}});
  // Only unmasked inputs in an enabled group contribute. // see RL9
  wire pc_event = |(pc_toggle & pin_change_mask & pc_group_en);

  wire p0_now = pin_sync[16];
  wire p0_old = pin_prev[16];
  wire p1_now = pin_sync[17];
  wire p1_old = pin_prev[17];

  // One sense select serves both pins, shared code for both pins. // see RL11 RL16
  wire level_mode = (sense_control == eiv_pkg::SENSE_LOW);
  wire p0_edge = (sense_control == eiv_pkg::SENSE_ANY) ? (p0_now ^ p0_old) :
    (sense_control == eiv_pkg::SENSE_FALL) ? (p0_old & ~p0_now) :
    (sense_control == eiv_pkg::SENSE_RISE) ? (~p0_old & p0_now) : 1'b0;
  wire p1_edge = (sense_control == eiv_pkg::SENSE_ANY) ? (p1_now ^ p1_old) :
    (sense_control == eiv_pkg::SENSE_FALL) ? (p1_old & ~p1_now) :
    (sense_control == eiv_pkg::SENSE_RISE) ? (~p1_old & p1_now) : 1'b0;

  // Level requests follow the synced pin low, with no flag,
  // so a write of one cannot clear them. // see RL12
  wire p0_level = level_mode & ~p0_now;
  wire p1_level = level_mode & ~p1_now;

  // Bus handshake decode.
  // A write runs once both halves are held.
  wire aw_take = i_awvalid & o_awready;
  wire w_take = i_wvalid & o_wready;
  wire wr_go = aw_held & w_held & ~o_bvalid;
  wire rd_take = i_arvalid & o_arready;
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}},
    {8{w_strb[0]}}};
  wire [31:0] wbits = w_data & wmask;
  wire wr_ctrl = wr_go & (aw_addr == eiv_pkg::ADDR_CONTROL);
  wire wr_mask = wr_go & (aw_addr == eiv_pkg::ADDR_MASK);
  wire wr_flags = wr_go & (aw_addr == eiv_pkg::ADDR_FLAGS);
  wire wr_pcmask = wr_go & (aw_addr == eiv_pkg::ADDR_PCMASK);
  wire wr_known = wr_ctrl | wr_mask | wr_flags | wr_pcmask |
    (aw_addr == eiv_pkg::ADDR_VECTOR) | (aw_addr == eiv_pkg::ADDR_PENDING);

  // Vector acknowledge from the core clears the matching flag. // see RL18
  // Only the flag of the named vector clears.
  wire ack_p0 = i_core_ack.ack &
    (i_core_ack.vector == eiv_pkg::VEC_PIN_ZERO);
  wire ack_p1 = i_core_ack.ack & (i_core_ack.vector == eiv_pkg::VEC_PIN_ONE);
  wire ack_pc = i_core_ack.ack &
    (i_core_ack.vector == eiv_pkg::VEC_PIN_CHANGE);

  // Write-one-to-clear requests from software.
  wire clr_p0 = wr_flags & wbits[eiv_pkg::FLAG_PIN_ZERO_BIT];
  wire clr_p1 = wr_flags & wbits[eiv_pkg::FLAG_PIN_ONE_BIT];
  wire clr_pc = wr_flags & wbits[eiv_pkg::FLAG_PC_BIT];

  // Next flag values: set wins over clear; level mode keeps both pin flags clear.
  // An event in a clear's cycle keeps the flag,
  // so that event is never lost.
  wire next_flag_zero = ~level_mode &
    (p0_edge | (ext_irq_flag_zero & ~clr_p0 & ~ack_p0)); // see RL18
  wire next_flag_one = ~level_mode &
    (p1_edge | (ext_irq_flag_one & ~clr_p1 & ~ack_p1)); // see RL18
  wire next_pc_flag = pc_event | (pin_change_flag & ~clr_pc & ~ack_pc);

  // Flag registers; events on pins driven as outputs count too. // see RL8
  // Software may drive its own output pin
  // to raise a request.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ext_irq_flag_zero <= 1'b0;
      ext_irq_flag_one <= 1'b0;
      pin_change_flag <= 1'b0;
    end else begin
      ext_irq_flag_zero <= next_flag_zero; // see RL13
      ext_irq_flag_one <= next_flag_one;
      pin_change_flag <= next_pc_flag;
    end
  end

  // Per-source pending vector, indexed by vector number.
  logic [eiv_pkg::NUM_VEC-1:0] pend;
  wire src_p0 = general_irq_mask[eiv_pkg::MASK_PIN_ZERO_BIT] &
    (ext_irq_flag_zero | p0_level);
  wire src_p1 = general_irq_mask[eiv_pkg::MASK_PIN_ONE_BIT] &
    (ext_irq_flag_one | p1_level);
  wire src_pc = pin_change_flag;

  // Assemble pending sources; reset entry is never an interrupt. // see RL1
  // Pin sources use words one, two, thirteen.
  genvar gv;
  generate
    for (gv = 0; gv < eiv_pkg::NUM_VEC; gv++) begin : g_pend
      if (gv == int'(eiv_pkg::VEC_RESET)) begin : g_rst
        assign pend[gv] = 1'b0;
      end else if (gv == int'(eiv_pkg::VEC_PIN_ZERO)) begin : g_p0
        assign pend[gv] = src_p0; // see RL2
      end else if (gv == int'(eiv_pkg::VEC_PIN_CHANGE)) begin : g_pc
        assign pend[gv] = src_pc; // see RL2
      end else if (gv == int'(eiv_pkg::VEC_PIN_ONE)) begin : g_p1
        assign pend[gv] = src_p1; // see RL2
      end else begin : g_per
        // Peripheral sources sit at their fixed words. // see RL3 RL4 RL5 RL6
        assign pend[gv] = i_periph_req[gv];
      end
    end
  endgenerate

  // Lowest pending number wins; others stay pending. // see RL20
  // The downward scan leaves the lowest bit;
  // word zero is never requested.
  logic [4:0] next_vec;
  logic next_any;
  always_comb begin
    next_vec = eiv_pkg::VEC_RESET;
    next_any = 1'b0;
    for (int k = eiv_pkg::NUM_VEC - 1; k > 0; k--) begin
      if (pend[k]) begin
        next_vec = 5'(k);
        next_any = 1'b1;
      end
    end
  end

  // Request goes out only with global enable set. // see RL19 RL7
  // It drops a cycle after each acknowledge so
  // the cleared flag can leave the vector.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_core_req <= '0;
    end else begin
      o_core_req.req <= next_any & global_en & ~i_core_ack.ack;
      o_core_req.vector <= next_vec;
    end
  end

  // Registered stand-in for the clockless wake path: silicon would
  // use the raw pins, here they pass the synchroniser first, so wake
  // needs the clock in this model. // see RL10 RL14
  // Unmasked pin change toggles.
  wire wake_pc = |(pc_toggle & pin_change_mask);
  // Pin zero held low while level sensing is enabled.
  wire wake_level = level_mode &
    general_irq_mask[eiv_pkg::MASK_PIN_ZERO_BIT] & ~p0_now;
  wire wake_raw = wake_pc | wake_level | next_any;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wake <= 1'b0;
    end else begin
      o_wake <= wake_raw;
    end
  end

  // Settings registers, written through the byte strobes.
  // Fields sit in the low byte; the pin change mask spans the low two bytes.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sense_control <= eiv_pkg::SENSE_LOW;
      global_en <= 1'b0;
      general_irq_mask <= 8'h00;
      pin_change_mask <= eiv_pkg::PCMASK_RESET;
    end else begin
      if (wr_ctrl & w_strb[0]) begin
        sense_control <= {w_data[eiv_pkg::SENSE_HI_BIT],
          w_data[eiv_pkg::SENSE_LO_BIT]};
        global_en <= w_data[eiv_pkg::GLOBAL_EN_BIT];
      end
      if (wr_mask & w_strb[0]) begin
        // Low four bits are reserved and stay zero.
        general_irq_mask <= {w_data[7:4], 4'h0};
      end
      if (wr_pcmask) begin
        pin_change_mask <= (pin_change_mask & ~wmask[15:0]) | wbits[15:0];
      end
    end
  end

  // Write channel: hold address and data until both have arrived.
  // Readies stay low until the answer is taken,
  // so writes never overtake.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= eiv_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= {i_awaddr[7:2], 2'h0};
        o_awready <= 1'b0;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
        o_wready <= 1'b0;
      end
      if (wr_go) begin
        // Unmapped offsets answer with a slave error.
        o_bvalid <= 1'b1;
        o_bresp <= wr_known ? eiv_pkg::RESP_OKAY : eiv_pkg::RESP_SLVERR;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
      if (o_bvalid & i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  // Read mux over the register map.
  // Reserved bits read as zero.
  wire [7:0] flags_rd = {ext_irq_flag_one, ext_irq_flag_zero,
    pin_change_flag, 5'h00};
  wire [7:0] ra = {i_araddr[7:2], 2'h0};
  wire ra_known = (ra == eiv_pkg::ADDR_CONTROL) |
    (ra == eiv_pkg::ADDR_MASK) | (ra == eiv_pkg::ADDR_FLAGS) |
    (ra == eiv_pkg::ADDR_PCMASK) | (ra == eiv_pkg::ADDR_VECTOR) |
    (ra == eiv_pkg::ADDR_PENDING);
  wire [31:0] rd_mux =
    (ra == eiv_pkg::ADDR_CONTROL) ?
      {24'h000000, global_en, 5'h00, sense_control} :
    (ra == eiv_pkg::ADDR_MASK) ? {24'h000000, general_irq_mask} :
    (ra == eiv_pkg::ADDR_FLAGS) ? {24'h000000, flags_rd} :
    (ra == eiv_pkg::ADDR_PCMASK) ? {16'h0000, pin_change_mask} :
    (ra == eiv_pkg::ADDR_VECTOR) ?
      {26'h0000000, o_core_req.req, o_core_req.vector} :
    (ra == eiv_pkg::ADDR_PENDING) ? {13'h0000, pend} : 32'h0000_0000;

  // Read channel: one read at a time, answered the cycle after address.
  // Data are latched at the take edge.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= eiv_pkg::RESP_OKAY;
    end else begin
      if (rd_take) begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        o_rdata <= rd_mux;
        o_rresp <= ra_known ? eiv_pkg::RESP_OKAY : eiv_pkg::RESP_SLVERR;
      end else if (o_rvalid & i_rready) begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end

endmodule : eiv_top

// file: tb/eiv_top_properties.sv
/*
 * Port checker for the external interrupt and vector unit.
 * Assumes one clock domain and the active-low asynchronous reset; it is
 * bound to every eiv_top instance by the statement at the foot.
 */
module eiv_top_checker (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [eiv_pkg::NUM_VEC-1:0] i_periph_req,
  input wire eiv_pkg::eiv_ack_type i_core_ack,
  input wire eiv_pkg::eiv_req_type o_core_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // All properties share the one clock and the reset.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  // Address and data of a write taken on the same edge.
  sequence s_wr_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  // A response that must stand while the master is not ready.
  sequence s_b_wait;
    o_bvalid && !i_bready;
  endsequence
  chk_wr_answer: assert property (s_wr_taken |=> ##1 o_bvalid)
    else $error("write response late");
  chk_b_holds: assert property (s_b_wait |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  chk_r_holds: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
  chk_rd_answer: assert property (i_arvalid && o_arready |=>
    o_rvalid && !o_arready)
    else $error("read answer late");
  chk_busy_refuse: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("new write accepted while busy");
  chk_vec_range: assert property (o_core_req.req |->
    o_core_req.vector inside {[5'h01:5'h12]})
    else $error("vector outside the table");
  chk_low_first: assert property (o_core_req.req &&
    $past(i_periph_req[3]) |-> o_core_req.vector <= 5'h03)
    else $error("higher vector served first");
  chk_ack_drops: assert property (i_core_ack.ack |=>
    !o_core_req.req)
    else $error("request stands after acknowledge");
endmodule : eiv_top_checker

bind eiv_top eiv_top_checker u_chk (.i_clk, .i_nrst, .i_awvalid,
  .o_awready, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
  .i_arvalid, .o_arready, .o_rdata, .o_rvalid, .i_rready,
  .i_periph_req, .i_core_ack, .o_core_req);

// file: tb/eiv_core_model.sv
/*
 * Behavioural processor core that fetches the presented vector.
 * Assumes the request is a registered level; i_wait sets how many
 * cycles the core lets pass before it acknowledges.
 */
module eiv_core_model (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_take,
  input wire logic [1:0] i_wait,
  input wire eiv_pkg::eiv_req_type i_req,
  output eiv_pkg::eiv_ack_type o_ack,
  output logic [4:0] o_last,
  output int o_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] delay; // Cycles already waited on this request.
  // Acknowledge once per request; while idle the vector field toggles so
  // that nothing can lean on a stale value.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ack <= '0;
      o_last <= 5'h1F;
      o_count <= 0;
      delay <= 2'h0;
    end else if (i_take && i_req.req && !o_ack.ack) begin
      if (delay == i_wait) begin
        o_ack <= {1'b1, i_req.vector};
        o_last <= i_req.vector;
        o_count <= o_count + 1;
        delay <= 2'h0;
      end else begin
        delay <= delay + 2'h1;
        o_ack <= {1'b0, ~o_ack.vector};
      end
    end else begin
      delay <= 2'h0;
      o_ack <= {1'b0, ~o_ack.vector};
    end
  end
endmodule : eiv_core_model

// file: tb/eiv_top_tb_top.sv
/*
 * Self-checking bench for the external interrupt and vector unit.
 * Assumes the core model answers vectors; the bench itself is the
 * AXI4-Lite master and drives the pins.
 */
module eiv_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // One peripheral case: extra requests beside the expected winner.
  typedef struct packed {
    logic [18:0] also;
    logic [4:0] vec;
  } eiv_row_type;
  localparam logic [1:0] OK = eiv_pkg::RESP_OKAY;
  localparam logic [1:0] BAD = eiv_pkg::RESP_SLVERR;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0] i_wstrb = 4'hF;
  logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0;
  logic i_rready = 0, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic i_ext_irq_pin_zero = 1'b1, i_ext_irq_pin_one = 1'b1, o_wake;
  logic [15:0] i_pin_change_inputs = 16'h0;
  logic [18:0] i_periph_req = 19'h0;
  eiv_pkg::eiv_ack_type i_core_ack;
  eiv_pkg::eiv_req_type o_core_req;
  logic take = 1'b0;
  logic [1:0] slow = 2'h2;
  logic [4:0] last;
  int count, miscompares = 0, comparisons = 0;
  eiv_row_type rows [17] = '{'{19'h0, 5'h03}, '{19'h0, 5'h04},
    '{19'h0, 5'h05}, '{19'h0, 5'h06}, '{19'h0, 5'h07}, '{19'h0, 5'h08},
    '{19'h0, 5'h09}, '{19'h0, 5'h0A}, '{19'h0, 5'h0B}, '{19'h0, 5'h0C},
    '{19'h0, 5'h0E}, '{19'h0, 5'h0F}, '{19'h0, 5'h10}, '{19'h0, 5'h11},
    '{19'h0, 5'h12}, '{19'h40200, 5'h04}, '{19'h22007, 5'h0C}};
  always #20 i_clk = ~i_clk;
  eiv_top u_dut (.i_clk, .i_nrst, .i_awaddr, .i_awvalid, .o_awready,
    .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid,
    .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
    .o_rvalid, .i_rready, .i_ext_irq_pin_zero, .i_ext_irq_pin_one,
    .i_pin_change_inputs, .i_periph_req, .i_core_ack, .o_core_req,
    .o_wake);
  eiv_core_model u_core (.i_clk, .i_nrst, .i_take(take), .i_wait(slow),
    .i_req(o_core_req), .o_ack(i_core_ack), .o_last(last),
    .o_count(count));
  // Count one comparison and report a mismatch at once.
  task automatic chk(input logic [31:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc
  // Write one word; handshakes are judged on settled values between edges.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic at, wt, bt, bv;
    logic [1:0] r;
    int n;
    n = 0;
    bt = 0;
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    while (!bt && n < 50) begin
      @(negedge i_clk);
      at = i_awvalid && o_awready;
      wt = i_wvalid && o_wready;
      bv = o_bvalid;
      bt = bv && i_bready;
      if (bt) r = o_bresp;
      @(posedge i_clk);
      if (at) i_awvalid <= 1'b0;
      if (wt) i_wvalid <= 1'b0;
      if (bv && !bt) i_bready <= 1'b1;
      n++;
    end
    i_bready <= 1'b0;
    chk(32'(r), 32'(er), "write response");
  endtask : wr
  // Read one word; the data are compared only when an OKAY answer is expected.
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    logic at, rt, rv;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    rt = 0;
    i_araddr <= a;
    i_arvalid <= 1'b1;
    while (!rt && n < 50) begin
      @(negedge i_clk);
      at = i_arvalid && o_arready;
      rv = o_rvalid;
      rt = rv && i_rready;
      if (rt) d = o_rdata;
      if (rt) r = o_rresp;
      @(posedge i_clk);
      if (at) i_arvalid <= 1'b0;
      if (rv && !rt) i_rready <= 1'b1;
      n++;
    end
    i_rready <= 1'b0;
    chk(32'(r), 32'(er), "read response");
    if (er == OK) chk(d, ed, "read data");
  endtask : rd
  // Wait for the core to take a vector, then compare which one.
  task automatic took(input logic [4:0] v);
    int c0, n;
    c0 = count;
    n = 0;
    while (count == c0 && n < 100) begin
      @(negedge i_clk);
      n++;
    end
    @(posedge i_clk);
    chk(32'(last), 32'(v), "vector taken");
  endtask : took
  task automatic give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  // Cuts a hang short well after the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    give_verdict();
  end
  // Main sequence.
  initial begin
    cyc(12);
    i_nrst <= 1'b1;
    cyc(1);
    rd(8'h00, 32'h0, OK);
    rd(8'h0C, 32'h0000FFC8, OK);
    rd(8'h1C, 32'h0, BAD);
    wr(8'h18, 32'hFF, BAD);
    $display("test done: reset values and unmapped offsets");
    wr(8'h00, 32'h80, OK);
    foreach (rows[i]) begin
      i_periph_req <= (19'h1 << rows[i].vec) | rows[i].also;
      cyc(3);
      chk(32'(o_core_req), {26'h0, 1'b1, rows[i].vec}, "vector");
      rd(8'h14, 32'((19'h1 << rows[i].vec | rows[i].also) & 19'h7DFF8),
         OK);
    end
    i_periph_req <= 19'h0;
    cyc(3);
    $display("test done: peripheral vectors");
    wr(8'h04, 32'h40, OK);
    for (int s = 0; s < 4; s++) begin
      wr(8'h00, 32'h80 | s, OK);
      wr(8'h08, 32'hE0, OK);
      i_ext_irq_pin_zero <= 1'b0;
      cyc(6);
      rd(8'h08, (s == 1 || s == 2) ? 32'h40 : 32'h0, OK);
      chk(32'(o_core_req), (s != 3) ? 32'h21 : 32'h0, "fall");
      if (s == 0) chk(32'(o_wake), 32'h1, "wake");
      wr(8'h08, 32'h40, OK);
      i_ext_irq_pin_zero <= 1'b1;
      cyc(6);
      rd(8'h08, (s == 1 || s == 3) ? 32'h40 : 32'h0, OK);
      chk(32'(o_core_req.req), 32'(s == 1 || s == 3), "rise");
    end
    $display("test done: sense codes");
    wr(8'h04, 32'h80, OK);
    wr(8'h08, 32'hE0, OK);
    i_ext_irq_pin_one <= 1'b0;
    cyc(4);
    i_ext_irq_pin_one <= 1'b1;
    cyc(6);
    chk(32'(o_core_req), 32'h2D, "pin one vector");
    rd(8'h08, 32'h80, OK);
    wr(8'h08, 32'h80, OK);
    rd(8'h08, 32'h0, OK);
    $display("test done: pin one and clear by one");
    wr(8'h00, 32'h03, OK);
    wr(8'h04, 32'h20, OK);
    i_pin_change_inputs <= 16'h0101;
    cyc(6);
    rd(8'h08, 32'h0, OK);
    i_pin_change_inputs <= 16'h0109;
    cyc(6);
    rd(8'h08, 32'h20, OK);
    chk(32'(o_core_req.req), 32'h0, "global off");
    wr(8'h00, 32'h83, OK);
    cyc(3);
    chk(32'(o_core_req), 32'h22, "pin change vector");
    $display("test done: pin change");
    wr(8'h04, 32'h60, OK);
    i_ext_irq_pin_zero <= 1'b0;
    cyc(4);
    i_ext_irq_pin_zero <= 1'b1;
    i_periph_req <= 19'h00020;
    cyc(6);
    take <= 1'b1;
    took(5'h01);
    slow <= 2'h0;
    took(5'h02);
    took(5'h05);
    take <= 1'b0;
    rd(8'h08, 32'h0, OK);
    i_periph_req <= 19'h0;
    $display("test done: priority and fetch");
    i_nrst <= 1'b0;
    cyc(3);
    chk(32'(o_core_req.req), 32'h0, "request in reset");
    i_nrst <= 1'b1;
    cyc(1);
    rd(8'h00, 32'h0, OK);
    $display("test done: second reset");
    give_verdict();
  end
endmodule : eiv_top_tb_top
